// *** verilog/pcrc_pkg.sv ***
package pcrc_pkg;
    // Register offsets (word index on the plain register port)
    localparam logic [3:0] ADDR_CTRL1      = 4'h0;
    localparam logic [3:0] ADDR_CTRL2      = 4'h1;
    localparam logic [3:0] ADDR_POLY_LO    = 4'h2;
    localparam logic [3:0] ADDR_POLY_HI    = 4'h3;
    localparam logic [3:0] ADDR_DATA_LO    = 4'h4;
    localparam logic [3:0] ADDR_DATA_HI    = 4'h5;
    localparam logic [3:0] ADDR_RESULT_LO  = 4'h6;
    localparam logic [3:0] ADDR_RESULT_HI  = 4'h7;
    localparam logic [3:0] ADDR_IRQ_STAT   = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK   = 4'h9;
    // Control one fields
    localparam int CTL1_ENABLE_POS = 15;
    localparam int CTL1_GO_POS     = 4;
    localparam int CTL1_FULL_POS   = 7;
    localparam int CTL1_EMPTY_POS  = 6;
    localparam int CTL1_BUSY_POS   = 5;
    localparam int CTL1_VALID_WORD_COUNT_LSB  = 8;
    // Control two fields
    localparam int CTL2_POLY_LENGTH_FIELD_LSB   = 0;
    localparam int CTL2_DATA_WIDTH_FIELD_LSB = 8;
    // Depth thresholds on the width field and resulting depths
    localparam logic [4:0] DW_WIDE_MIN = 5'h10;
    localparam logic [4:0] DW_MID_MIN  = 5'h08;
    localparam logic [4:0] DEPTH_WIDE  = 5'h04;
    localparam logic [4:0] DEPTH_MID   = 5'h08;
    localparam logic [4:0] DEPTH_NARROW = 5'h10;
    localparam int FIFO_SLOTS = 16;
    // Interrupt status bits
    localparam int IRQ_DONE_POS  = 0;
    localparam int IRQ_EMPTY_POS = 1;
    localparam int IRQ_FULL_POS  = 2;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pcrc_bus_t;
endpackage

// *** verilog/pcrc_top.sv ***
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ns
module pcrc_top (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire pcrc_pkg::pcrc_bus_t bus,
    output logic [15:0]              rdata,
    output logic                     irq
);
    typedef enum logic [1:0] {
        PCRC_IDLE  = 2'b01,
        PCRC_SHIFT = 2'b10
    } pcrc_state_t;

    pcrc_state_t state_reg;
    pcrc_state_t state_next;
    logic        enable_reg;
    logic        go_reg;
    logic [4:0]  poly_length_field_reg;
    logic [4:0]  data_width_field_reg;
    logic [31:0] poly_reg;
    logic [15:0] lo_hold_reg;
    logic [31:0] fifo_mem [pcrc_pkg::FIFO_SLOTS];
    logic [3:0]  wr_ptr_reg;
    logic [3:0]  rd_ptr_reg;
    logic [4:0]  count_reg;
    logic [31:0] buf_reg;
    logic [5:0]  bits_left_reg;
    logic [31:0] crc_reg;
    logic [2:0]  stat_reg;
    logic [2:0]  mask_reg;
    logic [15:0] rdata_reg;

    // Width and depth decode
    wire  [5:0]  width_bits = {1'b0, data_width_field_reg} + 6'h01;
    wire  [4:0]  depth = (data_width_field_reg >= pcrc_pkg::DW_WIDE_MIN) ? pcrc_pkg::DEPTH_WIDE :
                         (data_width_field_reg >= pcrc_pkg::DW_MID_MIN) ? pcrc_pkg::DEPTH_MID :
                         pcrc_pkg::DEPTH_NARROW;
    wire         fifo_full  = (count_reg == depth);
    wire         fifo_empty = (count_reg == 5'h00);
    wire         top_in_high = (data_width_field_reg >= pcrc_pkg::DW_WIDE_MIN);

    // Bus decode
    wire         wr_ctrl1 = bus.wr && (bus.addr == pcrc_pkg::ADDR_CTRL1);
    wire         wr_ctrl2 = bus.wr && (bus.addr == pcrc_pkg::ADDR_CTRL2);
    wire         wr_plo   = bus.wr && (bus.addr == pcrc_pkg::ADDR_POLY_LO);
    wire         wr_phi   = bus.wr && (bus.addr == pcrc_pkg::ADDR_POLY_HI);
    wire         wr_dlo   = bus.wr && (bus.addr == pcrc_pkg::ADDR_DATA_LO) && !fifo_full;
    wire         wr_dhi   = bus.wr && (bus.addr == pcrc_pkg::ADDR_DATA_HI) && !fifo_full;
    wire         wr_stat  = bus.wr && (bus.addr == pcrc_pkg::ADDR_IRQ_STAT);
    wire         wr_mask  = bus.wr && (bus.addr == pcrc_pkg::ADDR_IRQ_MASK);
    // Word completes on the half that holds the top data bit
    wire         push = enable_reg && (top_in_high ? wr_dhi : wr_dlo);
    wire  [31:0] push_word = top_in_high ? {bus.wdata, lo_hold_reg} : {16'h0000, bus.wdata};
    wire  [31:0] width_mask = 32'hffffffff >> (6'd32 - width_bits);
    wire         pop = enable_reg && (state_reg == PCRC_IDLE) && go_reg && !fifo_empty;
    wire         shifting = (state_reg == PCRC_SHIFT);
    wire         last_step = shifting && (bits_left_reg <= 6'h02);
    wire         done_ev = last_step && fifo_empty;

    // Full polynomial: registers plus forced zero and top terms
    wire  [32:0] poly_full = {1'b0, poly_reg | 32'h00000001}
                             | (33'h1 << ({1'b0, poly_length_field_reg} + 6'h01));
    wire  [32:0] order_bit = 33'h1 << ({1'b0, poly_length_field_reg} + 6'h01);

    // One bit of the LFSR, MSB first; result kept below the order bit
    function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic din,
                                             input logic [32:0] poly, input logic [32:0] top);
        logic [32:0] wide;
        logic        fb;
        wide = {1'b0, crc} << 1;
        fb   = ((|(wide & top)) ^ din);
        wide = wide & ~top;
        if (fb) begin
            // Terms at or above the order have no engine bit, so they are dropped
            wide = wide ^ (poly & (top - 33'h1));
        end
        crc_step = wide[31:0];
    endfunction

    wire  [5:0]  msb_idx  = bits_left_reg - 6'h01;
    wire         bit_a    = buf_reg[msb_idx[4:0]];
    wire         bit_b    = (bits_left_reg >= 6'h02) ? buf_reg[5'(msb_idx - 6'h01)] : 1'b0;
    wire  [31:0] crc_one  = crc_step(crc_reg, bit_a, poly_full, order_bit);
    wire  [31:0] crc_two  = (bits_left_reg >= 6'h02) ? crc_step(crc_one, bit_b, poly_full, order_bit) : crc_one;

    // Shift engine sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PCRC_IDLE: begin
                if (pop) begin
                    state_next = PCRC_SHIFT;
                end
            end
            PCRC_SHIFT: begin
                if (!enable_reg || (last_step && !(go_reg && !fifo_empty))) begin
                    state_next = PCRC_IDLE;
                end
            end
            default: state_next = PCRC_IDLE;
        endcase
    end

    // Configuration registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            enable_reg <= 1'b0;
            go_reg     <= 1'b0;
            poly_length_field_reg   <= 5'h00;
            data_width_field_reg <= 5'h00;
            poly_reg   <= 32'h00000000;
            mask_reg   <= 3'h0;
        end else begin
            if (wr_ctrl1) begin
                enable_reg <= bus.wdata[pcrc_pkg::CTL1_ENABLE_POS];
                go_reg     <= bus.wdata[pcrc_pkg::CTL1_GO_POS];
            end
            if (wr_ctrl2) begin
                poly_length_field_reg   <= bus.wdata[pcrc_pkg::CTL2_POLY_LENGTH_FIELD_LSB +: 5];
                data_width_field_reg <= bus.wdata[pcrc_pkg::CTL2_DATA_WIDTH_FIELD_LSB +: 5];
            end
            if (wr_plo) begin
                poly_reg[15:0] <= bus.wdata;
            end
            if (wr_phi) begin
                poly_reg[31:16] <= bus.wdata;
            end
            if (wr_mask) begin
                mask_reg <= bus.wdata[2:0];
            end
        end
    end

    // FIFO storage; narrow words are masked to the width on entry
    always_ff @(posedge clock) begin
        if (wr_dlo) begin
            lo_hold_reg <= bus.wdata;
        end
        if (push) begin
            fifo_mem[wr_ptr_reg] <= push_word & width_mask;
        end
    end

    // Pointers and valid-word count; disable clears them
    always_ff @(posedge clock) begin
        if (sys_rst || !enable_reg) begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_reg  <= 5'h00;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg + 4'h1) & 4'(depth - 5'h01);
            end
            if (pop || (last_step && go_reg && !fifo_empty)) begin
                rd_ptr_reg <= (rd_ptr_reg + 4'h1) & 4'(depth - 5'h01);
            end
            count_reg <= count_reg + 5'(push) - 5'(pop || (last_step && go_reg && !fifo_empty));
        end
    end

    // Buffer, shift and remainder
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg     <= PCRC_IDLE;
            buf_reg       <= 32'h00000000;
            bits_left_reg <= 6'h00;
            crc_reg       <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            if (pop || (last_step && go_reg && !fifo_empty && enable_reg)) begin
                buf_reg       <= fifo_mem[rd_ptr_reg];
                bits_left_reg <= width_bits;
            end else if (shifting) begin
                bits_left_reg <= (bits_left_reg >= 6'h02) ? bits_left_reg - 6'h02 : 6'h00;
            end
            // A new setup restarts the remainder even mid-shift, so no stale high bits survive
            if (wr_ctrl2) begin
                crc_reg <= 32'h00000000;
            end else if (shifting) begin
                crc_reg <= crc_two;
            end
        end
    end

    // Sticky status; a new event beats a clear in the same cycle
    // Full event on the push that fills, empty event on the take that drains
    wire       take     = enable_reg && (pop || (last_step && go_reg && !fifo_empty));
    wire       full_ev  = push && !take && (count_reg == 5'(depth - 5'h01));
    wire       empty_ev = take && !push && (count_reg == 5'h01);
    wire [2:0] events   = {full_ev, empty_ev, done_ev};
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stat_reg <= 3'h0;
        end else begin
            stat_reg <= (stat_reg & ~(wr_stat ? bus.wdata[2:0] : 3'h0)) | events;
        end
    end
    assign irq = |(stat_reg & mask_reg);

    // Read mux; data one cycle after the strobe
    wire [15:0] ctrl1_rd = ({15'h0000, enable_reg} << pcrc_pkg::CTL1_ENABLE_POS)
                         | ({11'h000, count_reg} << pcrc_pkg::CTL1_VALID_WORD_COUNT_LSB)
                         | ({15'h0000, fifo_full} << pcrc_pkg::CTL1_FULL_POS)
                         | ({15'h0000, fifo_empty} << pcrc_pkg::CTL1_EMPTY_POS)
                         | ({15'h0000, shifting} << pcrc_pkg::CTL1_BUSY_POS)
                         | ({15'h0000, go_reg} << pcrc_pkg::CTL1_GO_POS);
    wire [15:0] rd_mux =
        (bus.addr == pcrc_pkg::ADDR_CTRL1)     ? ctrl1_rd :
        (bus.addr == pcrc_pkg::ADDR_CTRL2)     ? {3'h0, data_width_field_reg, 3'h0, poly_length_field_reg} :
        (bus.addr == pcrc_pkg::ADDR_POLY_LO)   ? poly_reg[15:0] :
        (bus.addr == pcrc_pkg::ADDR_POLY_HI)   ? poly_reg[31:16] :
        (bus.addr == pcrc_pkg::ADDR_RESULT_LO) ? crc_reg[15:0] :
        (bus.addr == pcrc_pkg::ADDR_RESULT_HI) ? crc_reg[31:16] :
        (bus.addr == pcrc_pkg::ADDR_IRQ_STAT)  ? {13'h0000, stat_reg} :
        (bus.addr == pcrc_pkg::ADDR_IRQ_MASK)  ? {13'h0000, mask_reg} :
        pcrc_pkg::RESET_WORD;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_reg <= pcrc_pkg::RESET_WORD;
        end else begin
            rdata_reg <= bus.rd ? rd_mux : pcrc_pkg::RESET_WORD;
        end
    end
    assign rdata = rdata_reg;

    // Checks
    // They watch the engine's own state; the bus is only assumed to follow
    // the one-cycle strobe discipline of the plain register port
    property p_count_clear;
        @(posedge clock) disable iff (sys_rst) !enable_reg |=> count_reg == 5'h00;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("count not cleared");
    // A full FIFO must refuse the push, never wrap over the oldest word
    property p_full_flag;
        @(posedge clock) disable iff (sys_rst) fifo_full |-> !push;
    endproperty
    a_full_flag: assert property (p_full_flag) else $error("push while full");
    property p_no_over;
        @(posedge clock) disable iff (sys_rst) count_reg <= depth;
    endproperty
    a_no_over: assert property (p_no_over) else $error("fifo overflow");
    property p_push_inc;
        @(posedge clock) disable iff (sys_rst) push && !pop && !shifting |=> count_reg == $past(count_reg) + 5'h01;
    endproperty
    a_push_inc: assert property (p_push_inc) else $error("count did not increment");
    property p_start;
        @(posedge clock) disable iff (sys_rst) pop |=> shifting && bits_left_reg == width_bits;
    endproperty
    a_start: assert property (p_start) else $error("shift did not start");
    property p_two_bits;
        @(posedge clock) disable iff (sys_rst)
            shifting && enable_reg && bits_left_reg > 6'h02 |=> bits_left_reg == $past(bits_left_reg) - 6'h02;
    endproperty
    a_two_bits: assert property (p_two_bits) else $error("not two bits per cycle");
    property p_idle_nogo;
        @(posedge clock) disable iff (sys_rst) !shifting && !go_reg |=> !shifting;
    endproperty
    a_idle_nogo: assert property (p_idle_nogo) else $error("shift without go");
    // Set wins over a clear of the same bit in the same cycle
    property p_irq;
        @(posedge clock) disable iff (sys_rst) done_ev |=> stat_reg[pcrc_pkg::IRQ_DONE_POS];
    endproperty
    a_irq: assert property (p_irq) else $error("done status not set");
    property p_crc_hold;
        @(posedge clock) disable iff (sys_rst) !shifting && !wr_ctrl2 |=> crc_reg == $past(crc_reg);
    endproperty
    a_crc_hold: assert property (p_crc_hold) else $error("result changed while idle");

    // Disable stops the engine at once
    property p_disable_idle;
        @(posedge clock) disable iff (sys_rst) !enable_reg |=> !shifting;
    endproperty
    a_disable_idle: assert property (p_disable_idle) else $error("shifting while disabled");

    // Disable empties the FIFO by rewinding both pointers
    property p_ptr_clear;
        @(posedge clock) disable iff (sys_rst) !enable_reg |=> wr_ptr_reg == 4'h0 && rd_ptr_reg == 4'h0;
    endproperty
    a_ptr_clear: assert property (p_ptr_clear) else $error("pointers not cleared");

    // Each word moved into the buffer takes one off the count
    property p_pop_dec;
        @(posedge clock) disable iff (sys_rst) take && !push |=> count_reg == $past(count_reg) - 5'h01;
    endproperty
    a_pop_dec: assert property (p_pop_dec) else $error("count did not decrement");

    // Back-to-back words reload the buffer with no idle cycle
    property p_reload;
        @(posedge clock) disable iff (sys_rst)
            enable_reg && last_step && go_reg && !fifo_empty |=> bits_left_reg == $past(width_bits);
    endproperty
    a_reload: assert property (p_reload) else $error("buffer not reloaded");

    // Read data stand only in the cycle after the strobe
    property p_rdata_idle;
        @(posedge clock) disable iff (sys_rst) !bus.rd |=> rdata == pcrc_pkg::RESET_WORD;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");

    // The remainder never holds a bit at or above the order
    property p_order_clean;
        @(posedge clock) disable iff (sys_rst) (({1'b0, crc_reg} & ~(order_bit - 33'h1)) == 33'h0);
    endproperty
    a_order_clean: assert property (p_order_clean) else $error("remainder above order");

    // Draining the last word raises the empty status
    property p_empty_status;
        @(posedge clock) disable iff (sys_rst) empty_ev |=> stat_reg[pcrc_pkg::IRQ_EMPTY_POS];
    endproperty
    a_empty_status: assert property (p_empty_status) else $error("empty status not set");

    // Filling the FIFO raises the full status
    property p_full_status;
        @(posedge clock) disable iff (sys_rst) full_ev |=> stat_reg[pcrc_pkg::IRQ_FULL_POS];
    endproperty
    a_full_status: assert property (p_full_status) else $error("full status not set");

    // Writing a one clears the status bit when no new event comes
    property p_clear_one;
        @(posedge clock) disable iff (sys_rst)
            wr_stat && bus.wdata[pcrc_pkg::IRQ_DONE_POS] && !done_ev |=> !stat_reg[pcrc_pkg::IRQ_DONE_POS];
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("status not cleared");

    // Main scenarios
    c_reload: cover property (@(posedge clock) enable_reg && last_step && go_reg && !fifo_empty);
    c_irq: cover property (@(posedge clock) irq);
    c_push: cover property (@(posedge clock) push);
    c_full: cover property (@(posedge clock) fifo_full && enable_reg);
    c_done: cover property (@(posedge clock) done_ev);
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {
        logic [4:0]  dw;
        logic [4:0]  poly_length_field;
        logic [31:0] terms;
        logic [31:0] data;
    } pcrc_row_t;

    logic                clock;
    logic                sys_rst;
    pcrc_pkg::pcrc_bus_t bus;
    logic [15:0]         rdata;
    logic                irq;
    int                  num_errors;
    int                  cmp_count;
    logic [15:0]         v;
    logic [4:0]          dws [3] = '{5'd16, 5'd8, 5'd7};
    logic [4:0]          deps [3] = '{5'd4, 5'd8, 5'd16};
    // Width, order, terms, data; the result comes from the bit-serial model below
    pcrc_row_t           rows [6] = '{
        '{5'd15, 5'd15, 32'h0000_1021, 32'h0000_1234},
        '{5'd7, 5'd7, 32'h0000_0007, 32'h0000_00a5},
        '{5'd5, 5'd4, 32'h0000_0005, 32'h0000_00ff},
        '{5'd31, 5'd31, 32'h04c1_1db7, 32'hdead_beef},
        '{5'd23, 5'd15, 32'h0000_8004, 32'h00ab_cdef},
        '{5'd0, 5'd0, 32'h0000_0000, 32'h0000_0001}};

    pcrc_top i_dut (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .irq(irq));

    // Clock of 100 ns period
    always #50 clock = ~clock;

    // Reference remainder, MSB first, top and zero terms always present
    function automatic logic [31:0] crc_model(input pcrc_row_t r);
        logic [31:0] c;
        logic [31:0] msk;
        logic        fb;
        c = 32'h0000_0000;
        msk = (r.poly_length_field == 5'd31) ? 32'hffff_ffff : ((32'h0000_0001 << (r.poly_length_field + 1)) - 1);
        for (int i = 31; i >= 0; i--) begin
            if (i <= r.dw) begin
                fb = c[r.poly_length_field] ^ r.data[i];
                c = (c << 1) & msk;
                if (fb) begin
                    c = c ^ ((r.terms | 32'h0000_0001) & msk);
                end
            end
        end
        return c;
    endfunction

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Disable first so each job starts from an empty FIFO
    task automatic setup(input logic [4:0] dw, input logic [4:0] poly_length_field, input logic [31:0] terms);
        wr(pcrc_pkg::ADDR_CTRL1, 16'h0000);
        wr(pcrc_pkg::ADDR_CTRL2, {3'b000, dw, 3'b000, poly_length_field});
        wr(pcrc_pkg::ADDR_POLY_LO, terms[15:0]);
        wr(pcrc_pkg::ADDR_POLY_HI, terms[31:16]);
        wr(pcrc_pkg::ADDR_CTRL1, 16'h8000);
    endtask

    task automatic run_row(input pcrc_row_t r);
        logic [15:0] lo;
        logic [15:0] hi;
        setup(r.dw, r.poly_length_field, r.terms);
        wr(pcrc_pkg::ADDR_DATA_LO, r.data[15:0]);
        if (r.dw >= 5'd16) begin
            rd(pcrc_pkg::ADDR_CTRL1, v);
            chk(v[12:8], 0);
            wr(pcrc_pkg::ADDR_DATA_HI, r.data[31:16]);
        end
        rd(pcrc_pkg::ADDR_CTRL1, v);
        chk(v[12:8], 1);
        wr(pcrc_pkg::ADDR_CTRL1, 16'h8010);
        if (r.dw >= 5'd15) begin
            rd(pcrc_pkg::ADDR_CTRL1, v);
            chk(v[5], 1);
        end
        repeat (20) @(posedge clock);
        rd(pcrc_pkg::ADDR_CTRL1, v);
        chk({v[12:8], v[6], v[5]}, 7'b0000010);
        rd(pcrc_pkg::ADDR_RESULT_LO, lo);
        rd(pcrc_pkg::ADDR_RESULT_HI, hi);
        chk({hi, lo}, crc_model(r));
    endtask

    task automatic results;
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs about 480 cycles
    initial begin
        repeat (8000) @(posedge clock);
        num_errors++;
        results();
    end

    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        bus = '0;
        num_errors = 0;
        cmp_count = 0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        // Reset values, unmapped index reads zero; empty flag is up with count zero
        rd(pcrc_pkg::ADDR_CTRL1, v);
        chk(v, 16'h0040);
        rd(pcrc_pkg::ADDR_CTRL2, v);
        chk(v, 16'h0000);
        rd(4'hf, v);
        chk({v, irq}, 17'h0_0000);
        for (int k = 0; k < 6; k++) begin
            run_row(rows[k]);
        end
        // Depth per width band, one push beyond full is dropped
        for (int k = 0; k < 3; k++) begin
            setup(dws[k], 5'd15, 32'h0000_1021);
            wr(pcrc_pkg::ADDR_IRQ_STAT, 16'h0007);
            for (int n = 0; n <= deps[k]; n++) begin
                wr(pcrc_pkg::ADDR_DATA_LO, 16'h00a5);
                if (dws[k] >= 5'd16) begin
                    wr(pcrc_pkg::ADDR_DATA_HI, 16'h0001);
                end
            end
            rd(pcrc_pkg::ADDR_CTRL1, v);
            chk({v[12:8], v[7]}, {deps[k], 1'b1});
            rd(pcrc_pkg::ADDR_IRQ_STAT, v);
            chk(v[2], 1);
            wr(pcrc_pkg::ADDR_CTRL1, 16'h0000);
            wr(pcrc_pkg::ADDR_DATA_LO, 16'h00a5);
            rd(pcrc_pkg::ADDR_CTRL1, v);
            chk({v[12:8], v[7], v[6]}, 7'b0000001);
        end
        // Interrupt: masked, unmasked, then cleared by writing one
        wr(pcrc_pkg::ADDR_IRQ_STAT, 16'h0007);
        wr(pcrc_pkg::ADDR_IRQ_MASK, 16'h0000);
        run_row(rows[1]);
        chk(irq, 0);
        rd(pcrc_pkg::ADDR_IRQ_STAT, v);
        chk(v[0], 1);
        chk(v[1], 1);
        wr(pcrc_pkg::ADDR_IRQ_MASK, 16'h0001);
        #1;
        chk(irq, 1);
        wr(pcrc_pkg::ADDR_IRQ_STAT, 16'h0001);
        #1;
        chk(irq, 0);
        // Reset in mid-run clears the count and control
        setup(5'd7, 5'd7, 32'h0000_0007);
        wr(pcrc_pkg::ADDR_DATA_LO, 16'h0033);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(pcrc_pkg::ADDR_CTRL1, v);
        chk(v, 16'h0040);
        chk(irq, 0);
        results();
    end
endmodule
